// File: dtcp_pkg.sv
`default_nettype none
package dtcp_pkg;

  // apb address and data widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h088;
  localparam logic [9:0] IDX_MODE = 10'h089;
  localparam logic [9:0] IDX_CL0  = 10'h08A;
  localparam logic [9:0] IDX_CL1  = 10'h08B;
  localparam logic [9:0] IDX_CH0  = 10'h08C;
  localparam logic [9:0] IDX_CH1  = 10'h08D;

  // control register bit positions
  localparam int unsigned CTL_RUN0 = 4;
  localparam int unsigned CTL_OVF0 = 5;
  localparam int unsigned CTL_RUN1 = 6;
  localparam int unsigned CTL_OVF1 = 7;

  // mode register: timer 1 nibble offset, field positions inside a nibble
  localparam int unsigned MOD_T1_LSB = 4;
  localparam int unsigned MOD_SRC    = 2;
  localparam int unsigned MOD_GATE   = 3;

  // reset values and counter limits
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [7:0] BYTE_TOP   = 8'hFF;
  localparam logic [4:0] PRESC_TOP  = 5'h1F;
  localparam logic [4:0] PRESC_ONE  = 5'h01;
  localparam logic [7:0] BYTE_ONE   = 8'h01;
  localparam int unsigned PERIPH_DIV = 6;

  // operating modes of the two-bit mode field
  typedef enum logic [1:0] {
    MODE_PRESC,
    MODE_16,
    MODE_RELOAD,
    MODE_SPLIT
  } dtcp_mode_t;

endpackage
`default_nettype wire

// File: dtcp_timer_pair.sv
// How it works
// R1 - 16-bit mode: low byte carries into high byte, high overflow sets flag.
// R2 - setting run bit only enables counting, counts are never cleared by it.
// R3 - software stops a timer before presetting its count bytes.
// R4 - software stops a timer before changing its source or mode fields.
// R5 - source 0: count once every peripheral cycle.
// R6 - source 1: sample count pin per peripheral cycle, count high-then-low samples.
// R7 - pin edge recognised within two peripheral cycles, count shows the cycle after.
// R8 - external source holds each level at least one peripheral cycle.
// R9 - gate clear: run bit alone; gate set: gate pin also controls counting.
// R10 - rollover from all ones sets the overflow flag and interrupt request.
// R11 - interrupt service acknowledge clears the overflow flag.
// R12 - 13-bit mode: low five bits prescale by 32, carry into high byte.
// R13 - auto-reload: low byte counts, reloads from untouched high byte on overflow.
// R14 - split mode: timer 0 low byte is a normal 8-bit timer or counter.
// R15 - split mode: timer 0 high byte counts clock, uses timer 1 run and flag.
// R16 - timer 1 in mode 3 halts and keeps its count.
// R17 - timer 0 uses mode low nibble and control bits 4,5; timer 1 mode high nibble and control bits 6,7.
// R18 - timer 1 overflow drives the baud tick, also flagless during split mode.
// R19 - one count step per six timer clock periods.
// R20 - mode field 00 prescaled, 01 16-bit, 10 auto-reload, 11 split or hold.
// R21 - with gating, count only while gate pin high and run bit set.
// R22 - all count bytes reset to zero.
// R23 - count and gate pins are synchronised before edge detection or gating.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dtcp_timer_pair
  import dtcp_pkg::*;
#(
  parameter int unsigned DIV = PERIPH_DIV
)(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              count_pin_0_i,
  input  wire logic              count_pin_1_i,
  input  wire logic              gate_pin_0_i,
  input  wire logic              gate_pin_1_i,
  input  wire logic              intr_ack_0_i,
  input  wire logic              intr_ack_1_i,
  output logic                   irq_0_o,
  output logic                   irq_1_o,
  output logic                   baud_tick_o
);

  // refuse a divider the tick counter cannot serve
  if (DIV < 2 || DIV > 255)
  begin : g_bad_div
    $error("dtcp_timer_pair: DIV must be 2..255");
  end

  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);

  logic [7:0]  div_cnt_ff;
  logic        tick_ff;
  logic [3:0]  pin_s1_ff;
  logic [3:0]  pin_s2_ff;
  logic [3:0]  pin_s3_ff;
  logic [3:0]  pin_filt_ff;
  logic [1:0]  smp_ff;
  logic [1:0]  run_ff;
  logic [1:0]  flag_ff;
  logic [7:0]  mode_ff;
  logic [7:0]  cl0_ff;
  logic [7:0]  ch0_ff;
  logic [7:0]  cl1_ff;
  logic [7:0]  ch1_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        baud_ff;

  logic [9:0]  idx;
  logic        hit;
  logic [7:0]  rd_byte;
  logic        wr_en;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        wr_cl0;
  logic        wr_ch0;
  logic        wr_cl1;
  logic        wr_ch1;
  dtcp_mode_t  mode0;
  dtcp_mode_t  mode1;
  logic        split0;
  logic [1:0]  fall;
  logic [1:0]  en;
  logic [1:0]  inc;
  logic        inc_h0;
  logic [16:0] res0;
  logic [16:0] res1;
  logic [7:0]  nxt_ch0;
  logic        ovf_h0;
  logic [1:0]  flag_set;
  logic [1:0]  ack;

  // one increment step of a timer in the given mode, result is {ovf, hi, lo}
  function automatic logic [16:0] dtcp_step(input dtcp_mode_t m, input logic [7:0] lo,
                                            input logic [7:0] hi, input logic step);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    if (step)
    begin
      unique case (m)
        MODE_PRESC:
        begin
          // upper low-byte bits just hold; they never feed the carry
          r[4:0] = lo[4:0] + PRESC_ONE;
          if (lo[4:0] == PRESC_TOP)
          begin
            r[15:8] = hi + BYTE_ONE;
            r[16]   = (hi == BYTE_TOP);
          end
        end
        MODE_16:     r = {1'b0, hi, lo} + 17'h00001;
        MODE_RELOAD: r = (lo == BYTE_TOP) ? {1'b1, hi, hi} : {1'b0, hi, lo + BYTE_ONE};
        MODE_SPLIT:  r = {lo == BYTE_TOP, hi, lo + BYTE_ONE};
      endcase
    end
    return r;
  endfunction

  // peripheral cycle tick, one pulse every DIV clocks
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_cnt_ff <= 8'h00;
      tick_ff    <= 1'b0;
    end
    else
    begin
      div_cnt_ff <= (div_cnt_ff == DIV_LAST) ? 8'h00 : div_cnt_ff + 8'h01; // [R19]
      tick_ff    <= (div_cnt_ff == DIV_LAST);
    end
  end

  // three-flop synchronisers; filtered level moves only when stages two and three agree
  for (genvar g = 0; g < 4; g++)
  begin : g_sync
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
      begin
        pin_s1_ff[g]   <= 1'b0;
        pin_s2_ff[g]   <= 1'b0;
        pin_s3_ff[g]   <= 1'b0;
        pin_filt_ff[g] <= 1'b0;
      end
      else
      begin
        pin_s1_ff[g] <= (g == 0) ? count_pin_0_i : (g == 1) ? count_pin_1_i :
                        (g == 2) ? gate_pin_0_i : gate_pin_1_i; // [R23]
        pin_s2_ff[g] <= pin_s1_ff[g];
        pin_s3_ff[g] <= pin_s2_ff[g];
        if (pin_s2_ff[g] == pin_s3_ff[g])
          pin_filt_ff[g] <= pin_s3_ff[g];
      end
    end
  end

  // field decode per timer
  assign mode0  = dtcp_mode_t'(mode_ff[1:0]); // [R17] [R20]
  assign mode1  = dtcp_mode_t'(mode_ff[MOD_T1_LSB+1:MOD_T1_LSB]);
  assign split0 = (mode0 == MODE_SPLIT);
  assign ack    = {intr_ack_1_i, intr_ack_0_i};

  // per-timer sampling, gating and increment
  for (genvar t = 0; t < 2; t++)
  begin : g_cnt
    localparam int unsigned NB = t * MOD_T1_LSB;

    // one sample per peripheral cycle; a high then low pair is one edge
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        smp_ff[t] <= 1'b0;
      else if (tick_ff)
        smp_ff[t] <= pin_filt_ff[t]; // [R6] [R7]
    end

    assign fall[t] = smp_ff[t] & ~pin_filt_ff[t];
    assign inc[t]  = en[t] & tick_ff & (mode_ff[NB+MOD_SRC] ? fall[t] : 1'b1); // [R5] [R6]
  end

  // timer 1 keeps running for the baud tick while timer 0 borrows its run bit
  assign en[0] = run_ff[0] & (~mode_ff[MOD_GATE] | pin_filt_ff[2]); // [R9] [R21] [R14]
  assign en[1] = (split0 ? 1'b1 : run_ff[1]) & (mode1 != MODE_SPLIT)
               & (~mode_ff[MOD_T1_LSB+MOD_GATE] | pin_filt_ff[3]); // [R9] [R16] [R18]

  // next counts; split mode hands timer 0 high byte to timer 1 run bit
  always_comb
  begin
    res0    = dtcp_step(mode0, cl0_ff, ch0_ff, inc[0]); // [R1] [R12] [R13] [R14]
    res1    = dtcp_step(mode1, cl1_ff, ch1_ff, inc[1]);
    inc_h0  = split0 & run_ff[1] & tick_ff; // [R15]
    nxt_ch0 = split0 ? ch0_ff + {7'h00, inc_h0} : res0[15:8];
    ovf_h0  = inc_h0 & (ch0_ff == BYTE_TOP);
    flag_set[0] = res0[16]; // [R10]
    flag_set[1] = split0 ? ovf_h0 : res1[16]; // [R15] [R18]
  end

  // apb decode; writes land on the access edge with pready high
  assign idx     = paddr_i[ADDR_W-1:2];
  assign hit     = (idx == IDX_CTRL) || (idx == IDX_MODE) || (idx == IDX_CL0) ||
                   (idx == IDX_CL1) || (idx == IDX_CH0) || (idx == IDX_CH1);
  assign wr_en   = psel_i & penable_i & pready_ff & pwrite_i & pstrb_i[0];
  assign wr_ctrl = wr_en & (idx == IDX_CTRL);
  assign wr_mode = wr_en & (idx == IDX_MODE);
  assign wr_cl0  = wr_en & (idx == IDX_CL0);
  assign wr_ch0  = wr_en & (idx == IDX_CH0);
  assign wr_cl1  = wr_en & (idx == IDX_CL1);
  assign wr_ch1  = wr_en & (idx == IDX_CH1);

  // read mux; low control bits belong to the external interrupt block and read zero
  always_comb
  begin
    unique case (idx)
      IDX_CTRL: rd_byte = {flag_ff[1], run_ff[1], flag_ff[0], run_ff[0], 4'h0};
      IDX_MODE: rd_byte = mode_ff;
      IDX_CL0:  rd_byte = cl0_ff;
      IDX_CH0:  rd_byte = ch0_ff;
      IDX_CL1:  rd_byte = cl1_ff;
      IDX_CH1:  rd_byte = ch1_ff;
      default:  rd_byte = 8'h00;
    endcase
  end

  // zero-wait slave: answer prepared in the setup cycle, ready in the first access cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end
    else
    begin
      pready_ff  <= psel_i & ~penable_i;
      pslverr_ff <= psel_i & ~penable_i & ~hit;
      if (psel_i & ~penable_i & ~pwrite_i)
        prdata_ff <= {24'h000000, rd_byte};
    end
  end

  // control and mode bits; run bit write leaves counts alone
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      run_ff  <= 2'b00;
      mode_ff <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        run_ff <= {pwdata_i[CTL_RUN1], pwdata_i[CTL_RUN0]}; // [R2] [R17]
      if (wr_mode)
        mode_ff <= pwdata_i[7:0]; // [R4]
    end
  end

  // overflow flags: hardware set beats acknowledge and software clear
  for (genvar f = 0; f < 2; f++)
  begin : g_flag
    localparam int unsigned FB = f ? CTL_OVF1 : CTL_OVF0;
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        flag_ff[f] <= 1'b0;
      else if (flag_set[f])
        flag_ff[f] <= 1'b1; // [R10]
      else if (wr_ctrl)
        flag_ff[f] <= pwdata_i[FB];
      else if (ack[f])
        flag_ff[f] <= 1'b0; // [R11]
    end
  end

  // count bytes; a software preset wins, stopping first is the caller's job
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cl0_ff <= BYTE_RST; // [R22]
      ch0_ff <= BYTE_RST;
      cl1_ff <= BYTE_RST;
      ch1_ff <= BYTE_RST;
    end
    else
    begin
      cl0_ff <= wr_cl0 ? pwdata_i[7:0] : res0[7:0]; // [R3]
      ch0_ff <= wr_ch0 ? pwdata_i[7:0] : nxt_ch0;
      cl1_ff <= wr_cl1 ? pwdata_i[7:0] : res1[7:0];
      ch1_ff <= wr_ch1 ? pwdata_i[7:0] : res1[15:8]; // [R13]
    end
  end

  // baud tick is the raw timer 1 overflow, independent of its flag
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      baud_ff <= 1'b0;
    else
      baud_ff <= res1[16]; // [R18]
  end

  assign prdata_o    = prdata_ff;
  assign pready_o    = pready_ff;
  assign pslverr_o   = pslverr_ff;
  assign irq_0_o     = flag_ff[0];
  assign irq_1_o     = flag_ff[1];
  assign baud_tick_o = baud_ff;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_tick_period: assert property (tick_ff |=> !tick_ff [*5] ##1 tick_ff) // [R19]
    else $error("peripheral tick period wrong");
  a_stop_holds: assert property (!run_ff[0] && !wr_cl0 |=> $stable(cl0_ff)) // [R2]
    else $error("stopped timer 0 low byte moved");
  a_ovf_flag: assert property (res0[16] |=> flag_ff[0] && irq_0_o) // [R10]
    else $error("overflow did not set flag 0");
  a_ack_clear: assert property (ack[1] && !flag_set[1] && !wr_ctrl |=> !irq_1_o) // [R11]
    else $error("acknowledge did not clear flag 1");
  a_reload_val: assert property (mode0 == MODE_RELOAD && inc[0] && cl0_ff == BYTE_TOP
                                 && !wr_cl0 && !wr_ch0 |=> cl0_ff == $past(ch0_ff) && $stable(ch0_ff)) // [R13]
    else $error("auto-reload value wrong");
  a_cascade_16: assert property (mode0 == MODE_16 && inc[0] && cl0_ff == BYTE_TOP
                                 && !wr_cl0 && !wr_ch0 |=> ch0_ff == $past(ch0_ff) + BYTE_ONE) // [R1]
    else $error("16-bit carry lost");
  a_presc_hold: assert property (mode0 == MODE_PRESC && cl0_ff[4:0] != PRESC_TOP
                                 && !wr_ch0 |=> $stable(ch0_ff)) // [R12]
    else $error("prescaler carried early");
  a_halt_t1: assert property (mode1 == MODE_SPLIT && !wr_cl1 && !wr_ch1
                              |=> $stable(cl1_ff) && $stable(ch1_ff)) // [R16]
    else $error("timer 1 moved in hold mode");
  a_gate_block: assert property (mode_ff[MOD_GATE] && !pin_filt_ff[2] |-> !inc[0]) // [R21]
    else $error("gated timer 0 counted");
  a_edge_count: assert property (mode_ff[MOD_SRC] && inc[0] |-> tick_ff && smp_ff[0]
                                 && !pin_filt_ff[0] && $past(tick_ff, DIV)) // [R6]
    else $error("counter stepped without falling edge");
  a_split_flag: assert property (split0 && ovf_h0 |=> irq_1_o) // [R15]
    else $error("split high overflow missed flag 1");

  c_ovf16: cover property (mode0 == MODE_16 && res0[16]);
  c_reload: cover property (mode1 == MODE_RELOAD && baud_ff);
  c_split: cover property (split0 && ovf_h0);
  c_pin_edge: cover property (mode_ff[MOD_SRC] && inc[0]);

endmodule
`default_nettype wire

// File: test_dual_timer_counter_pair.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_timer_counter_pair;
  import dtcp_pkg::*;

  // case equality so an unknown never passes
  `define CHK(nm, exp, got) \
    begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
        mismatches++; \
        $display("BAD %s expected %0h seen %0h", nm, exp, got); \
      end \
    end

  logic              sys_clk_i;
  logic              rst_b_i;
  logic              psel_i;
  logic              penable_i;
  logic              pwrite_i;
  logic [ADDR_W-1:0] paddr_i;
  logic [DATA_W-1:0] pwdata_i;
  logic [3:0]        pstrb_i;
  logic [DATA_W-1:0] prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  logic              count_pin_0_i;
  logic              count_pin_1_i;
  logic              gate_pin_0_i;
  logic              gate_pin_1_i;
  logic              intr_ack_0_i;
  logic              intr_ack_1_i;
  logic              irq_0_o;
  logic              irq_1_o;
  logic              baud_tick_o;
  logic              last_err;
  logic [7:0]        v1;
  logic [7:0]        v2;
  int                mismatches;
  int                total_checks;
  int                n;
  logic [9:0]        idx_tab [6];

  dtcp_timer_pair dut_u (
    .sys_clk_i     (sys_clk_i),
    .rst_b_i       (rst_b_i),
    .psel_i        (psel_i),
    .penable_i     (penable_i),
    .pwrite_i      (pwrite_i),
    .paddr_i       (paddr_i),
    .pwdata_i      (pwdata_i),
    .pstrb_i       (pstrb_i),
    .prdata_o      (prdata_o),
    .pready_o      (pready_o),
    .pslverr_o     (pslverr_o),
    .count_pin_0_i (count_pin_0_i),
    .count_pin_1_i (count_pin_1_i),
    .gate_pin_0_i  (gate_pin_0_i),
    .gate_pin_1_i  (gate_pin_1_i),
    .intr_ack_0_i  (intr_ack_0_i),
    .intr_ack_1_i  (intr_ack_1_i),
    .irq_0_o       (irq_0_o),
    .irq_1_o       (irq_1_o),
    .baud_tick_o   (baud_tick_o)
  );

  // 25 MHz system clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop();
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; waits for pready under a bound, never a fixed count
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int k;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= {idx, 2'b00};
    pwdata_i  <= {24'h000000, wd};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 20);
    rd = prdata_o[7:0];
    last_err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    apb(1'b1, idx, d, dummy);
  endtask

  task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    apb(1'b0, idx, 8'h00, v);
    `CHK(nm, exp, v)
  endtask

  // bounded wait on one of the event outputs: 0 irq_0, 1 irq_1, 2 baud tick
  task automatic wait_sig(input int which, input int lim);
    logic s;
    int k;
    k = 0;
    do
    begin
      @(posedge sys_clk_i);
      k++;
      s = (which == 0) ? irq_0_o : (which == 1) ? irq_1_o : baud_tick_o;
    end
    while (s !== 1'b1 && k < lim);
    if (s !== 1'b1)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask

  initial
  begin
    idx_tab = '{IDX_CTRL, IDX_MODE, IDX_CL0, IDX_CL1, IDX_CH0, IDX_CH1};
    mismatches = 0;
    total_checks = 0;
    rst_b_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = '0;
    pwdata_i = '0;
    pstrb_i = 4'hF;
    count_pin_0_i = 1'b1;
    count_pin_1_i = 1'b1;
    gate_pin_0_i = 1'b1;
    gate_pin_1_i = 1'b1;
    intr_ack_0_i = 1'b0;
    intr_ack_1_i = 1'b0;
    idle(5);
    rst_b_i <= 1'b1;
    // reset values of every register
    foreach (idx_tab[i])
      rd_chk("reset value", idx_tab[i], 8'h00);
    // unmapped index answers with an error and zero data
    apb(1'b0, 10'h000, 8'h00, v1);
    `CHK("unmapped error", 1'b1, last_err)
    `CHK("unmapped data", 8'h00, v1)
    // 16-bit timer 0 from FFFE: cascade, rollover flag, ack clears it
    wr(IDX_MODE, 8'h01);
    wr(IDX_CL0, 8'hFE);
    wr(IDX_CH0, 8'hFF);
    wr(IDX_CTRL, 8'h10);
    rd_chk("high kept at run", IDX_CH0, 8'hFF);
    wait_sig(0, 40);
    rd_chk("high after carry", IDX_CH0, 8'h00);
    intr_ack_0_i <= 1'b1;
    @(posedge sys_clk_i);
    intr_ack_0_i <= 1'b0;
    idle(2);
    `CHK("flag 0 after ack", 1'b0, irq_0_o)
    wr(IDX_CTRL, 8'h00);
    // 13-bit mode: upper low bits set must not block the prescaler carry
    wr(IDX_MODE, 8'h00);
    wr(IDX_CL0, 8'h7F);
    wr(IDX_CH0, 8'h10);
    wr(IDX_CTRL, 8'h10);
    idle(40);
    wr(IDX_CTRL, 8'h00);
    rd_chk("prescaled high", IDX_CH0, 8'h11);
    // counter mode: three falling edges, levels held well over a peripheral cycle
    wr(IDX_MODE, 8'h05);
    wr(IDX_CL0, 8'h00);
    wr(IDX_CTRL, 8'h10);
    repeat (3)
    begin
      count_pin_0_i <= 1'b0;
      idle(20);
      count_pin_0_i <= 1'b1;
      idle(20);
    end
    wr(IDX_CTRL, 8'h00);
    rd_chk("edge count", IDX_CL0, 8'h03);
    // gated timer: held while gate pin low, runs once it is high
    // gate lowered first: its synchroniser must settle before the run bit lands
    gate_pin_0_i <= 1'b0;
    wr(IDX_MODE, 8'h09);
    wr(IDX_CL0, 8'h00);
    wr(IDX_CTRL, 8'h10);
    idle(40);
    rd_chk("gated hold", IDX_CL0, 8'h00);
    gate_pin_0_i <= 1'b1;
    idle(40);
    wr(IDX_CTRL, 8'h00);
    apb(1'b0, IDX_CL0, 8'h00, v1);
    `CHK("gated run", 1'b1, v1 != 8'h00)
    // timer 1 auto-reload: baud period is two steps of six clocks
    wr(IDX_MODE, 8'h20);
    wr(IDX_CL1, 8'hFE);
    wr(IDX_CH1, 8'hFE);
    wr(IDX_CTRL, 8'h40);
    wait_sig(2, 40);
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (baud_tick_o !== 1'b1 && n < 40);
    `CHK("baud period", 2 * PERIPH_DIV, n)
    `CHK("flag 1 on reload", 1'b1, irq_1_o)
    // stop but keep flag 1 set, so only the acknowledge can clear it
    wr(IDX_CTRL, 8'h80);
    rd_chk("reload high kept", IDX_CH1, 8'hFE);
    intr_ack_1_i <= 1'b1;
    @(posedge sys_clk_i);
    intr_ack_1_i <= 1'b0;
    idle(2);
    `CHK("flag 1 after ack", 1'b0, irq_1_o)
    // split mode: high byte of timer 0 runs on run 1 and raises flag 1
    wr(IDX_MODE, 8'h23);
    wr(IDX_CL0, 8'h00);
    wr(IDX_CH0, 8'hFE);
    wr(IDX_CTRL, 8'h40);
    wait_sig(1, 40);
    rd_chk("split low idle", IDX_CL0, 8'h00);
    // timer 1 in hold mode keeps its count
    wr(IDX_MODE, 8'h33);
    apb(1'b0, IDX_CL1, 8'h00, v1);
    idle(30);
    apb(1'b0, IDX_CL1, 8'h00, v2);
    `CHK("hold count", v1, v2)
    // timer 1 as gated event counter on its own pins; third edge comes while gated off
    wr(IDX_CTRL, 8'h00);
    wr(IDX_MODE, 8'hD0);
    wr(IDX_CL1, 8'h00);
    wr(IDX_CTRL, 8'h40);
    repeat (2)
    begin
      count_pin_1_i <= 1'b0;
      idle(20);
      count_pin_1_i <= 1'b1;
      idle(20);
    end
    gate_pin_1_i <= 1'b0;
    idle(10);
    count_pin_1_i <= 1'b0;
    idle(20);
    count_pin_1_i <= 1'b1;
    idle(20);
    wr(IDX_CTRL, 8'h00);
    rd_chk("timer 1 gated edges", IDX_CL1, 8'h02);
    report_and_stop();
  end

  `undef CHK
endmodule
`default_nettype wire
